// ===== src/disp_consts.svh
// Timing, reset and field constants for the panel timing and backlight block.
// Assumes inclusion by bare name from the disp_timing module, the only one that includes it.
//
// Contract
// R1 - Backlight enable comes from a PWM set by frequency and duty.
// R2 - PWM accepts 250 to 10000 Hz and runs at the programmed frequency.
// R3 - Host keeps PWM frequency at or below 1000 Hz for the backlight driver.
// R4 - Duty 0 to 128; active fraction of each period is duty over 128.
// R5 - Duty 0 holds backlight off; duty 128 holds it continuously on.
// R6 - Host sets 800 visible, 928 period, 88 offset, line sync 0 to 48.
// R7 - Host sets 480 visible, 525 period, 32 offset, frame sync 0 to 3.
// R8 - Host sets divisor 2, polarity 1, reorder 0, spread 1, dither 1.
// R9 - Drawing list runs once per line into a line buffer before output.
// R10 - Line buffer changes only for objects visible on the current line; the code also clears each entry to zero as it streams out.
// R11 - Counters wrap at totals; syncs and data enable follow programmed windows.
// R12 - PWM frequency and duty changes take effect at period boundaries.
`ifndef DISP_CONSTS_SVH
`define DISP_CONSTS_SVH
`define CLOCK_HZ 250000000
`define PWM_STEPS 128
`define PWM_TICK_THRESHOLD (`CLOCK_HZ / `PWM_STEPS)
`define PWM_HZ_MIN 14'h00FA
`define PWM_HZ_MAX 14'h2710
`define PWM_DUTY_FULL 8'h80
`define PWM_HZ_RESET 14'h00FA
`define PWM_DUTY_RESET 8'h00
`define H_VISIBLE_RESET 11'h320
`define H_PERIOD_RESET 11'h3A0
`define H_OFFSET_RESET 11'h058
`define H_SYNC_START_RESET 11'h000
`define H_SYNC_END_RESET 11'h030
`define V_VISIBLE_RESET 10'h1E0
`define V_PERIOD_RESET 10'h20D
`define V_OFFSET_RESET 10'h020
`define V_SYNC_START_RESET 10'h000
`define V_SYNC_END_RESET 10'h003
`endif

// ===== src/disp_pkg.sv
// Types shared by the panel timing and backlight block.
// Assumes the constants header sits beside it in src/.
package disp_pkg;
  // Line build sequence, Gray coded along wait, run, send
  typedef enum logic [1:0] {
    BUILD_WAIT = 2'b00,
    BUILD_RUN = 2'b01,
    BUILD_SEND = 2'b11
  } build_state_type;
endpackage

// ===== src/pixel_fifo.sv
// Dual-clock pixel FIFO with Gray-coded pointers and valid/ready on both sides.
// Assumes DEPTH is a power of two of at least 4 and one shared async reset.
module pixel_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic wr_clock_i,
  input wire logic rd_clock_i,
  input wire logic reset_n_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [WIDTH-1:0] rd_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] peer_s1;
    logic [AW:0] peer_s2;
  } side_type;

  side_type w, next_w, r, next_r;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // Full compares against the synced read pointer with top two bits inverted
  assign full = w.gray == {~w.peer_s2[AW:AW-1], w.peer_s2[AW-2:0]};
  assign empty = r.gray == r.peer_s2;
  assign wr_ready_o = !full;
  assign rd_valid_o = !empty;
  assign rd_data_o = mem[r.bin[AW-1:0]];

  // Write side pointer and read-pointer synchroniser
  always_comb begin
    next_w = w;
    next_w.peer_s1 = r.gray;
    next_w.peer_s2 = w.peer_s1;
    if (wr_valid_i && !full) begin
      next_w.bin = w.bin + 1'b1;
      next_w.gray = to_gray(next_w.bin);
    end
  end

  // Read side pointer and write-pointer synchroniser
  always_comb begin
    next_r = r;
    next_r.peer_s1 = w.gray;
    next_r.peer_s2 = r.peer_s1;
    if (rd_ready_i && !empty) begin
      next_r.bin = r.bin + 1'b1;
      next_r.gray = to_gray(next_r.bin);
    end
  end

  always_ff @(posedge wr_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      w <= '0;
    end else begin
      w <= next_w;
    end
  end

  always_ff @(posedge rd_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Storage has no reset; contents only matter once written
  always_ff @(posedge wr_clock_i) begin
    if (wr_valid_i && !full) begin
      mem[w.bin[AW-1:0]] <= wr_data_i;
    end
  end

  property p_no_overrun;
    @(posedge wr_clock_i) disable iff (!reset_n_i)
      full |=> w.bin == $past(w.bin);
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("fifo written while full");
endmodule // pixel_fifo

// ===== src/disp_timing.sv
// Panel timing generator, per-line buffer build and backlight PWM.
// Assumes pixel_clock_i is the panel clock, unrelated to clock_i, and that
// the configuration ports are driven from the clock_i domain.
`include "disp_consts.svh"
module disp_timing #(
  parameter int HW = 11,
  parameter int VW = 10,
  parameter int PW = 24,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic pixel_clock_i,
  input wire logic [13:0] backlight_pwm_frequency_i,
  input wire logic [7:0] backlight_duty_i,
  output logic backlight_enable_o,
  input wire logic [HW-1:0] horizontal_visible_pixels_i,
  input wire logic [HW-1:0] horizontal_line_period_i,
  input wire logic [HW-1:0] horizontal_active_offset_i,
  input wire logic [HW-1:0] line_sync_start_i,
  input wire logic [HW-1:0] line_sync_end_i,
  input wire logic [VW-1:0] vertical_visible_lines_i,
  input wire logic [VW-1:0] vertical_frame_period_i,
  input wire logic [VW-1:0] vertical_active_offset_i,
  input wire logic [VW-1:0] frame_sync_start_i,
  input wire logic [VW-1:0] frame_sync_end_i,
  input wire logic colour_pin_reorder_i,
  output logic line_start_o,
  output logic [VW-1:0] build_line_o,
  input wire logic draw_valid_i,
  input wire logic [HW-1:0] draw_x_i,
  input wire logic [PW-1:0] draw_pixel_i,
  input wire logic [VW-1:0] draw_line_first_i,
  input wire logic [VW-1:0] draw_line_last_i,
  input wire logic list_done_i,
  output logic line_sync_o,
  output logic frame_sync_o,
  output logic data_enable_o,
  output logic [PW-1:0] pixel_data_o
);
  import disp_pkg::*;

  localparam int CW = 5 * HW + 5 * VW + 1;

  typedef struct packed {
    logic [21:0] acc;
    logic [6:0] slot;
    logic [13:0] hz_live;
    logic [7:0] duty_live;
    logic bl;
    build_state_type state;
    logic [HW-1:0] send_x;
    logic [VW-1:0] line;
    logic line_start;
    logic restart;
    logic [2:0] frame_s;
    logic [CW-1:0] snap;
    logic req;
    logic [1:0] ack_s;
  } sys_type;

  typedef struct packed {
    logic [HW-1:0] h;
    logic [VW-1:0] v;
    logic [CW-1:0] cfg;
    logic [2:0] req_s;
    logic ack;
    logic frame_tog;
    logic hs;
    logic vs;
    logic de;
    logic [PW-1:0] pix;
  } pix_type;

  sys_type s, next_s;
  pix_type p, next_p;
  logic [PW-1:0] line_buf [2**HW];
  logic lb_we;
  logic [HW-1:0] lb_addr;
  logic [PW-1:0] lb_wdata;
  logic [CW-1:0] cfg_now;
  logic [13:0] hz_clamped;
  logic [22:0] acc_sum;
  logic boundary, tick, fifo_wr_ready, fifo_rd_valid, fifo_rd_ready, visible;
  logic [PW-1:0] fifo_rd_data;
  logic [HW-1:0] c_hvis, c_hper, c_hoff, c_hs0, c_hs1;
  logic [VW-1:0] c_vvis, c_vper, c_voff, c_vs0, c_vs1;
  logic c_reorder;

  assign cfg_now = {horizontal_visible_pixels_i, horizontal_line_period_i,
    horizontal_active_offset_i, line_sync_start_i, line_sync_end_i,
    vertical_visible_lines_i, vertical_frame_period_i, vertical_active_offset_i,
    frame_sync_start_i, frame_sync_end_i, colour_pin_reorder_i};
  assign {c_hvis, c_hper, c_hoff, c_hs0, c_hs1, c_vvis, c_vper, c_voff, c_vs0, c_vs1,
    c_reorder} = p.cfg;

  // Out-of-range requests are pinned to the supported span
  assign hz_clamped = (backlight_pwm_frequency_i < `PWM_HZ_MIN) ? `PWM_HZ_MIN :
    (backlight_pwm_frequency_i > `PWM_HZ_MAX) ? `PWM_HZ_MAX : backlight_pwm_frequency_i; // R2
  assign acc_sum = {1'b0, s.acc} + {9'h000, s.hz_live};
  assign tick = acc_sum >= 23'(`PWM_TICK_THRESHOLD);
  assign boundary = tick && (s.slot == 7'h7F);
  assign visible = (s.line >= draw_line_first_i) && (s.line <= draw_line_last_i);
  assign fifo_rd_ready = next_p.de;

  // System domain: PWM, line build sequencer, config handoff
  always_comb begin
    next_s = s;
    lb_we = 1'b0;
    lb_addr = draw_x_i;
    lb_wdata = draw_pixel_i;
    // Fractional accumulator gives 128 slots per period at hz_live
    if (tick) begin
      next_s.acc = 22'(acc_sum - 23'(`PWM_TICK_THRESHOLD)); // R2
      next_s.slot = s.slot + 1'b1;
    end else begin
      next_s.acc = acc_sum[21:0];
    end
    // New settings only at the wrap, so no pulse is ever cut short
    if (boundary) begin
      next_s.hz_live = hz_clamped; // R12
      next_s.duty_live = (backlight_duty_i > `PWM_DUTY_FULL) ? `PWM_DUTY_FULL
        : backlight_duty_i; // R12
    end
    next_s.bl = {1'b0, next_s.slot} < next_s.duty_live; // R1 R4 R5
    // Frame start toggle from the panel side, set beats consume
    next_s.frame_s = {s.frame_s[1:0], p.frame_tog};
    next_s.line_start = 1'b0;
    unique case (s.state)
      BUILD_WAIT: begin
        next_s.line_start = 1'b1; // R9
        next_s.state = BUILD_RUN;
      end
      BUILD_RUN: begin
        if (draw_valid_i && visible) begin
          lb_we = 1'b1; // R10
        end
        if (list_done_i) begin
          next_s.state = BUILD_SEND; // R9
          next_s.send_x = '0;
        end
      end
      BUILD_SEND: begin
        // Stream out and clear behind, so the next line starts blank
        lb_addr = s.send_x;
        lb_wdata = '0;
        if (fifo_wr_ready) begin
          lb_we = 1'b1;
          next_s.send_x = s.send_x + 1'b1;
          if (s.send_x == horizontal_visible_pixels_i - 1'b1) begin
            next_s.state = BUILD_WAIT;
            next_s.line = (s.restart || s.line == vertical_visible_lines_i - 1'b1) ? '0
              : s.line + 1'b1;
            next_s.restart = 1'b0;
          end
        end
      end
    endcase
    if (s.frame_s[2] != s.frame_s[1]) begin
      next_s.restart = 1'b1;
    end
    // Snapshot only when the panel side has acknowledged the last one
    next_s.ack_s = {s.ack_s[0], p.ack};
    if (s.ack_s[1] == s.req && cfg_now != s.snap) begin
      next_s.snap = cfg_now;
      next_s.req = ~s.req;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.hz_live <= `PWM_HZ_RESET;
      s.duty_live <= `PWM_DUTY_RESET;
      s.state <= BUILD_WAIT;
      s.snap <= {`H_VISIBLE_RESET, `H_PERIOD_RESET, `H_OFFSET_RESET, `H_SYNC_START_RESET,
        `H_SYNC_END_RESET, `V_VISIBLE_RESET, `V_PERIOD_RESET, `V_OFFSET_RESET,
        `V_SYNC_START_RESET, `V_SYNC_END_RESET, 1'b0};
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clock_i) begin
    if (lb_we) begin
      line_buf[lb_addr] <= lb_wdata;
    end
  end

  assign backlight_enable_o = s.bl;
  assign line_start_o = s.line_start;
  assign build_line_o = s.line;

  pixel_fifo #(
    .WIDTH(PW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wr_clock_i(clock_i),
    .rd_clock_i(pixel_clock_i),
    .reset_n_i(reset_n_i),
    .wr_valid_i(s.state == BUILD_SEND),
    .wr_ready_o(fifo_wr_ready),
    .wr_data_i(line_buf[s.send_x]),
    .rd_valid_o(fifo_rd_valid),
    .rd_ready_i(fifo_rd_ready),
    .rd_data_o(fifo_rd_data)
  );

  // Panel domain: counters, windows, config load
  always_comb begin
    next_p = p;
    next_p.req_s = {p.req_s[1:0], s.req};
    if (p.req_s[1] != p.req_s[2]) begin
      next_p.cfg = s.snap;
      next_p.ack = p.req_s[1];
    end
    // Wrap also guards against a period shrunk below the current count
    if (p.h >= c_hper - 1'b1) begin
      next_p.h = '0; // R11
      if (p.v >= c_vper - 1'b1) begin
        next_p.v = '0; // R11
        next_p.frame_tog = ~p.frame_tog;
      end else begin
        next_p.v = p.v + 1'b1;
      end
    end else begin
      next_p.h = p.h + 1'b1;
    end
    next_p.hs = (next_p.h >= c_hs0) && (next_p.h < c_hs1); // R11
    next_p.vs = (next_p.v >= c_vs0) && (next_p.v < c_vs1); // R11
    next_p.de = (next_p.h >= c_hoff) && ({1'b0, next_p.h} < {1'b0, c_hoff} + {1'b0, c_hvis})
      && (next_p.v >= c_voff) && ({1'b0, next_p.v} < {1'b0, c_voff} + {1'b0, c_vvis}); // R11
    // An empty FIFO during the window shows black rather than stale data
    if (next_p.de && fifo_rd_valid) begin
      next_p.pix = c_reorder ? {fifo_rd_data[7:0], fifo_rd_data[15:8], fifo_rd_data[23:16]}
        : fifo_rd_data;
    end else begin
      next_p.pix = '0;
    end
  end

  always_ff @(posedge pixel_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p <= '0;
      // Counters park on the last count so the first edge opens line and frame at zero
      p.h <= `H_PERIOD_RESET - 11'h001;
      p.v <= `V_PERIOD_RESET - 10'h001;
      p.cfg <= {`H_VISIBLE_RESET, `H_PERIOD_RESET, `H_OFFSET_RESET, `H_SYNC_START_RESET,
        `H_SYNC_END_RESET, `V_VISIBLE_RESET, `V_PERIOD_RESET, `V_OFFSET_RESET,
        `V_SYNC_START_RESET, `V_SYNC_END_RESET, 1'b0};
    end else begin
      p <= next_p;
    end
  end

  assign line_sync_o = p.hs;
  assign frame_sync_o = p.vs;
  assign data_enable_o = p.de;
  assign pixel_data_o = p.pix;

  property p_duty_off;
    @(posedge clock_i) disable iff (!reset_n_i)
      s.duty_live == 8'h00 |-> !backlight_enable_o;
  endproperty
  a_duty_off: assert property (p_duty_off) else $error("backlight on at duty zero"); // R5

  property p_duty_full;
    @(posedge clock_i) disable iff (!reset_n_i)
      s.duty_live == `PWM_DUTY_FULL |-> backlight_enable_o;
  endproperty
  a_duty_full: assert property (p_duty_full) else $error("backlight off at full duty"); // R5

  property p_hold_mid_period;
    @(posedge clock_i) disable iff (!reset_n_i)
      !boundary |=> $stable(s.duty_live) && $stable(s.hz_live);
  endproperty
  a_hold_mid_period: assert property (p_hold_mid_period) else $error("pwm setting mid-period"); // R12

  property p_hz_range;
    @(posedge clock_i) disable iff (!reset_n_i)
      s.hz_live >= `PWM_HZ_MIN && s.hz_live <= `PWM_HZ_MAX;
  endproperty
  a_hz_range: assert property (p_hz_range) else $error("pwm frequency out of range"); // R2

  property p_draw_visible;
    @(posedge clock_i) disable iff (!reset_n_i)
      s.state == BUILD_RUN && lb_we |-> visible;
  endproperty
  a_draw_visible: assert property (p_draw_visible) else $error("draw on invisible line"); // R10

  property p_build_send;
    @(posedge clock_i) disable iff (!reset_n_i)
      s.state == BUILD_RUN && list_done_i |=> s.state == BUILD_SEND ##1 !line_start_o;
  endproperty
  a_build_send: assert property (p_build_send) else $error("line not sent after list"); // R9

  property p_line_wrap;
    @(posedge pixel_clock_i) disable iff (!reset_n_i)
      p.h == c_hper - 1'b1 && $stable(p.cfg) |=> p.h == '0;
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("line counter did not wrap"); // R11

  property p_de_start;
    @(posedge pixel_clock_i) disable iff (!reset_n_i)
      $rose(data_enable_o) |-> p.h == c_hoff && p.v >= c_voff;
  endproperty
  a_de_start: assert property (p_de_start) else $error("data enable starts off offset"); // R11

  property p_hsync_start;
    @(posedge pixel_clock_i) disable iff (!reset_n_i)
      $rose(line_sync_o) |-> p.h == c_hs0;
  endproperty
  a_hsync_start: assert property (p_hsync_start) else $error("line sync starts early"); // R11
endmodule // disp_timing

// ===== test/panel_model.sv
// Panel and backlight driver model: measures sync and enable windows, collects pixels.
// Assumes panel outputs are registered on the rising pixel clock edge.
module panel_model (
  input wire logic pixel_clock_i,
  input wire logic reset_n_i,
  input wire logic line_sync_i,
  input wire logic frame_sync_i,
  input wire logic data_enable_i,
  input wire logic [23:0] pixel_i,
  input wire logic backlight_enable_i,
  output logic pix_valid_o,
  output logic [23:0] pix_o,
  output logic backlight_seen_o,
  output int line_period_o,
  output int line_sync_width_o,
  output int active_offset_o,
  output int active_width_o,
  output int frame_lines_o,
  output int frame_sync_lines_o,
  output int active_lines_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int hcnt, hs_cnt, de_cnt, vcnt, vs_cnt, dl_cnt;
  logic ls_d, fs_d, de_d;
  // Passive receiver; widths close at falling edges so a partial window never counts
  always @(posedge pixel_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {ls_d, fs_d, de_d, pix_valid_o, backlight_seen_o} <= '0;
      {hcnt, hs_cnt, de_cnt, vcnt, vs_cnt, dl_cnt} <= '0;
      pix_o <= '0;
    end else begin
      ls_d <= line_sync_i;
      fs_d <= frame_sync_i;
      de_d <= data_enable_i;
      hcnt <= hcnt + 1;
      pix_valid_o <= data_enable_i && (pixel_i != 24'h0);
      pix_o <= pixel_i;
      if (backlight_enable_i) backlight_seen_o <= 1'b1;
      if (line_sync_i) hs_cnt <= hs_cnt + 1;
      if (data_enable_i) de_cnt <= de_cnt + 1;
      if (line_sync_i && !ls_d) begin
        line_period_o <= hcnt;
        hcnt <= 1;
        vcnt <= vcnt + 1;
        if (frame_sync_i) vs_cnt <= vs_cnt + 1;
      end
      if (!line_sync_i && ls_d) begin
        line_sync_width_o <= hs_cnt;
        hs_cnt <= 0;
      end
      if (data_enable_i && !de_d) begin
        active_offset_o <= hcnt;
        dl_cnt <= dl_cnt + 1;
      end
      if (!data_enable_i && de_d) begin
        active_width_o <= de_cnt;
        de_cnt <= 0;
      end
      // Frame start closes the line tallies of the frame before
      if (frame_sync_i && !fs_d) begin
        frame_lines_o <= vcnt;
        vcnt <= 0;
        active_lines_o <= dl_cnt;
        dl_cnt <= 0;
      end
      if (!frame_sync_i && fs_d) begin
        frame_sync_lines_o <= vs_cnt;
        vs_cnt <= 0;
      end
    end
  end
endmodule // panel_model

// ===== test/tb_top.sv
// Self-checking bench: panel timing windows, line build stream, backlight hold.
// Assumes disp_timing and panel_model are compiled before it.
module tb_top;
  import disp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Short panel so that several frames fit in the run
  localparam int HV = 16, HP = 40, HO = 10, HSS = 2, HSE = 6;
  localparam int VV = 4, VP = 8, VO = 2, VSS = 1, VSE = 3;
  logic clock_i = 0, pixel_clock_i = 0, reset_n_i = 0;
  logic [13:0] freq;
  logic [7:0] duty;
  logic bl, line_start, list_done, draw_valid, line_sync, frame_sync, de, pix_valid, bl_seen;
  logic [9:0] build_line, first, last;
  logic [10:0] draw_x;
  logic [23:0] draw_pix, pixel, pix;
  int lp, lsw, aoff, aw, fl, fsl, al, errors = 0, num_checks = 0, ln;
  logic [23:0] exp_q[$];
  logic [23:0] lbuf[16];
  logic [31:0] seed = 32'h9B9B;

  always #2 clock_i = ~clock_i;
  // Pixel clock offset so its edges never meet the system clock edges
  always begin
    #1.3;
    forever #15 pixel_clock_i = ~pixel_clock_i;
  end

  disp_timing dut_u (.clock_i(clock_i), .reset_n_i(reset_n_i), .pixel_clock_i(pixel_clock_i),
    .backlight_pwm_frequency_i(freq), .backlight_duty_i(duty), .backlight_enable_o(bl),
    .horizontal_visible_pixels_i(11'(HV)), .horizontal_line_period_i(11'(HP)),
    .horizontal_active_offset_i(11'(HO)), .line_sync_start_i(11'(HSS)),
    .line_sync_end_i(11'(HSE)), .vertical_visible_lines_i(10'(VV)),
    .vertical_frame_period_i(10'(VP)), .vertical_active_offset_i(10'(VO)),
    .frame_sync_start_i(10'(VSS)), .frame_sync_end_i(10'(VSE)),
    .colour_pin_reorder_i(1'b1),
    .line_start_o(line_start), .build_line_o(build_line), .draw_valid_i(draw_valid),
    .draw_x_i(draw_x), .draw_pixel_i(draw_pix), .draw_line_first_i(first),
    .draw_line_last_i(last), .list_done_i(list_done), .line_sync_o(line_sync),
    .frame_sync_o(frame_sync), .data_enable_o(de), .pixel_data_o(pixel));

  panel_model panel_u (.pixel_clock_i(pixel_clock_i), .reset_n_i(reset_n_i),
    .line_sync_i(line_sync), .frame_sync_i(frame_sync), .data_enable_i(de), .pixel_i(pixel),
    .backlight_enable_i(bl), .pix_valid_o(pix_valid), .pix_o(pix),
    .backlight_seen_o(bl_seen), .line_period_o(lp), .line_sync_width_o(lsw),
    .active_offset_o(aoff), .active_width_o(aw), .frame_lines_o(fl),
    .frame_sync_lines_o(fsl), .active_lines_o(al));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Render one line: random draws, some on invisible objects, then a stray draw
  task automatic build_one();
    int i, k;
    logic [23:0] p;
    for (k = 0; k < 40000 && line_start !== 1'b1; k++) @(negedge clock_i);
    if (line_start !== 1'b1) begin
      errors++;
      $display("MISMATCH line start wait expected 1 seen 0");
      print_verdict();
    end
    check_val("build line range", 1, {31'h0, build_line < 10'(VV)});
    for (i = 0; i < 16; i++) lbuf[i] = 24'h0;
    for (i = 0; i < 5; i++) begin
      draw_x = 11'(rnd() % 16);
      p = 24'(rnd()) | 24'h1;
      draw_pix = p;
      first = 10'(rnd() % 4);
      last = 10'(rnd() % 4);
      draw_valid = 1'b1;
      if (first <= build_line && build_line <= last) lbuf[draw_x] = p;
      @(negedge clock_i);
    end
    draw_valid = 1'b0;
    list_done = 1'b1;
    duty = 8'(rnd() % 129);
    @(negedge clock_i);
    list_done = 1'b0;
    draw_valid = 1'b1;
    draw_x = 11'h0;
    draw_pix = 24'hFFFFFF;
    first = 10'h0;
    last = 10'(VV - 1);
    @(negedge clock_i);
    draw_valid = 1'b0;
    // Output swaps red and blue bytes with reordering on
    for (i = 0; i < 16; i++) if (lbuf[i] != 24'h0) exp_q.push_back({lbuf[i][7:0],
      lbuf[i][15:8], lbuf[i][23:16]});
  endtask

  // Every nonzero pixel shown during data enable, in build order
  always @(posedge pixel_clock_i) begin
    if (pix_valid === 1'b1) begin
      if (exp_q.size() == 0) check_val("pixel", 32'h0, {8'h0, pix});
      else check_val("pixel", {8'h0, exp_q.pop_front()}, {8'h0, pix});
    end
  end

  initial begin
    freq = 14'h03E8;
    duty = 8'h40;
    {draw_valid, list_done} = 2'b00;
    {draw_x, draw_pix, first, last} = '0;
    repeat (10) @(negedge clock_i);
    reset_n_i = 1'b1;
    for (ln = 0; ln < 12; ln++) build_one();
    for (ln = 0; ln < 40000 && exp_q.size() != 0; ln++) @(negedge clock_i);
    check_val("pixels left", 0, exp_q.size());
    check_val("line period", HP, lp);
    check_val("line sync width", HSE - HSS, lsw);
    check_val("active offset", HO - HSS, aoff);
    check_val("active width", HV, aw);
    check_val("frame lines", VP, fl);
    check_val("frame sync lines", VSE - VSS, fsl);
    check_val("active lines", VV, al);
    // Reset period at duty 0 outlasts the run, so no new duty may show yet
    check_val("backlight seen", 0, {31'h0, bl_seen});
    check_val("backlight", 0, {31'h0, bl});
    print_verdict();
  end
endmodule // tb_top
